/* src/pvs_pkg.sv */
// Purpose: shared constants, modes and carriers of the valve input scaler
// Assumes: pclk at 40 MHz, APB addresses are byte addresses
// Notes: all offsets are word aligned
package pvs_pkg;
  localparam int CLK_PERIOD_NS = 25;
  localparam int CLK_HZ = 1000000000 / CLK_PERIOD_NS;
  localparam logic [25:0] ACC_WRAP = 26'(CLK_HZ);
  localparam logic [8:0] FREQ_MIN_HZ = 9'h028;
  localparam logic [8:0] FREQ_MAX_HZ = 9'h190;
  localparam logic [8:0] FREQ_RST = 9'h0C8;
  localparam logic [15:0] FULL_SCALE = 16'hFFFF;
  localparam logic [15:0] ERR_MIN_OFF = 16'h0000;
  localparam logic [15:0] ERR_MAX_RST = 16'hFFFF;
  localparam logic [15:0] SIG_MAX_RST = 16'hFFFF;
  localparam logic [19:0] DUTY_STEP = 20'h00040;

  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_ERR = 8'h04;
  localparam logic [7:0] A_IRAMP = 8'h08;
  localparam logic [7:0] A_SIG = 8'h0C;
  localparam logic [7:0] A_PT0 = 8'h10;
  localparam logic [7:0] A_PT4 = 8'h20;
  localparam logic [7:0] A_DIG0 = 8'h24;
  localparam logic [7:0] A_DIG1 = 8'h28;
  localparam logic [7:0] A_OFA = 8'h2C;
  localparam logic [7:0] A_ORA = 8'h30;
  localparam logic [7:0] A_OFB = 8'h34;
  localparam logic [7:0] A_ORB = 8'h38;
  localparam logic [7:0] A_STAT = 8'h3C;
  localparam logic [7:0] A_SETP = 8'h40;

  typedef enum logic [2:0] {
    IN_V5, IN_V10, IN_MA20, IN_OHM, IN_SENSOR, IN_DIGITAL, IN_PWM, IN_FREQ
  } pvs_in_type_t;

  typedef enum logic [1:0] {BIAS_UP, BIAS_CENTER, BIAS_DOWN} pvs_bias_t;

  typedef struct packed {
    logic [15:0] cur;
    logic [15:0] inp;
  } pvs_point_t;

  typedef struct packed {
    logic [8:0] freq;
    logic [15:0] down;
    logic [15:0] up;
  } pvs_out_cfg_t;
endpackage : pvs_pkg

/* src/pvs_ramp.sv */
// Purpose: slew limiter in units per second
// Assumes: rates in units per second, one unit per step
// Notes: a zero rate passes the target straight through
`timescale 1ns/1ps
`default_nettype none
module pvs_ramp
  import pvs_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [15:0] target,
  input wire logic [15:0] rate_up,
  input wire logic [15:0] rate_down,
  output logic [15:0] value
);
  typedef struct packed {
    logic [15:0] val;
    logic [25:0] acc;
  } pvs_ramp_st_t;

  pvs_ramp_st_t s;
  pvs_ramp_st_t next_s;
  logic [15:0] rate;
  logic [25:0] sum;

  // fractional accumulator gives exact rate without a divider
  always_comb begin
    next_s = s;
    rate = (target > s.val) ? rate_up : rate_down;
    sum = s.acc + 26'(rate);
    if (target == s.val) begin
      next_s.acc = '0;
    end else if (rate == 16'h0000) begin
      next_s.val = target;
      next_s.acc = '0;
    end else if (sum >= ACC_WRAP) begin
      next_s.acc = sum - ACC_WRAP;
      next_s.val = (target > s.val) ? s.val + 16'h0001 : s.val - 16'h0001;
    end else begin
      next_s.acc = sum;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign value = s.val;
endmodule : pvs_ramp
`default_nettype wire

/* src/pvs_coil_pwm.sv */
// Purpose: coil PWM with per-period current regulation
// Assumes: freq already clamped to 40..400 Hz
// Notes: duty steps once per period, so settling is slow by design
`timescale 1ns/1ps
`default_nettype none
module pvs_coil_pwm
  import pvs_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [8:0] freq,
  input wire logic [15:0] setpt,
  input wire logic [15:0] meas,
  input wire logic en,
  output logic coil
);
  typedef struct packed {
    logic [19:0] cnt;
    logic [19:0] per;
    logic [19:0] duty;
    logic out;
  } pvs_pwm_st_t;

  pvs_pwm_st_t s;
  pvs_pwm_st_t next_s;
  logic [19:0] per_now;

  always_comb begin
    next_s = s;
    per_now = 20'(CLK_HZ / int'(freq));
    next_s.cnt = s.cnt + 20'h00001;
    if (s.cnt >= s.per - 20'h00001) begin
      next_s.cnt = '0;
      next_s.per = per_now;
      if (!en || setpt == 16'h0000) begin
        next_s.duty = '0;
      end else if (meas < setpt && s.duty + DUTY_STEP <= per_now) begin
        next_s.duty = s.duty + DUTY_STEP;
      end else if (meas > setpt && s.duty >= DUTY_STEP) begin
        next_s.duty = s.duty - DUTY_STEP;
      end
    end
    next_s.out = en && (next_s.cnt < next_s.duty);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
      s.per <= 20'(CLK_HZ / int'(FREQ_RST));
    end else begin
      s <= next_s;
    end
  end

  assign coil = s.out;
endmodule : pvs_coil_pwm
`default_nettype wire

/* src/pvs_scaler.sv */
// Purpose: input bias, fault check, ramps, scaling and coil drive
// Assumes: in_sample is on pclk; comparator pins are asynchronous
// Notes: faults latch until reset
// Overview of operation
// - centre bias offered only for digital inputs, weak pull to mid level.
// - pull-down bias holds pin at ground, open switch reads low.
// - three-state input picks ground, float or battery coil current.
// - fault when input exceeds the error maximum.
// - error maximum at full scale disables the over-limit check.
// - fault when input falls below the error minimum.
// - error minimum of zero disables the under-limit check.
// - rising input limited to input ramp-up rate per second.
// - falling input limited to input ramp-down rate per second.
// - input ramp sits before the scaling stage.
// - analog scaling interpolates linearly over start, end and up to three breakpoints.
// - inputs outside signal minimum and maximum are dead bands.
// - outputs A and B each own frequency and ramp settings.
// - coil PWM frequency is 40 to 400 hertz.
// - coil current increases limited to output ramp-up rate.
// - coil current decreases limited to output ramp-down rate.
// - output ramp follows scaling, linear in milliamps per second.
// - input type selects voltage, current, resistance, sensor, digital, PWM, frequency.
// - pull-up bias holds pin at supply, open switch reads high.
`timescale 1ns/1ps
`default_nettype none
module pvs_scaler
  import pvs_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [15:0] in_sample,
  input wire logic in_above_hi,
  input wire logic in_below_lo,
  input wire logic [15:0] coil_ma_a,
  input wire logic [15:0] coil_ma_b,
  output logic pull_up_en,
  output logic pull_center_en,
  output logic pull_down_en,
  output logic coil_pwm_a,
  output logic coil_pwm_b,
  output logic fault
);
  typedef struct packed {
    pvs_in_type_t typ;
    pvs_bias_t bias;
    logic [1:0] nbp;
    logic b_en;
    logic [15:0] emin;
    logic [15:0] emax;
    logic [15:0] rup;
    logic [15:0] rdn;
    logic [15:0] smin;
    logic [15:0] smax;
    pvs_point_t [4:0] pt;
    logic [15:0] dgnd;
    logic [15:0] dflt;
    logic [15:0] dbat;
    pvs_out_cfg_t [1:0] oc;
    logic [2:0] hi_s;
    logic [2:0] lo_s;
    logic hi;
    logic lo;
    logic pu;
    logic pc;
    logic pd;
    logic over;
    logic under;
    logic flt;
    logic [15:0] setpt;
    logic [31:0] rdata;
  } pvs_scaler_st_t;

  pvs_scaler_st_t s;
  pvs_scaler_st_t next_s;
  logic [15:0] lim;
  logic [1:0][15:0] meas;
  logic [1:0][15:0] ramp;
  logic [1:0] pwm;
  logic [1:0] en;
  logic [31:0] rd;
  logic [31:0] m;
  logic [31:0] w;
  logic mapped;
  logic pt_hit;
  logic [2:0] pt_idx;
  logic dig;
  logic [15:0] dsel;
  logic [1:0] seg;
  logic [3:1] past_bp;
  pvs_point_t lo_p;
  pvs_point_t hi_p;
  logic signed [17:0] dx;
  logic signed [17:0] dc;
  logic signed [17:0] den;
  logic signed [35:0] prod;
  logic signed [35:0] quo;
  logic [15:0] interp;
  logic [15:0] scaled;

  // whole word is clamped, so an oversize request lands at the top instead of wrapping
  function automatic logic [8:0] clamp_f(input logic [31:0] f);
    if (f < 32'(FREQ_MIN_HZ)) begin
      return FREQ_MIN_HZ;
    end else if (f > 32'(FREQ_MAX_HZ)) begin
      return FREQ_MAX_HZ;
    end
    return f[8:0];
  endfunction : clamp_f

  // input ramp ahead of scaling
  pvs_ramp u_in_ramp (
    .pclk(pclk),
    .presetn(presetn),
    .target(in_sample),
    .rate_up(s.rup),
    .rate_down(s.rdn),
    .value(lim)
  );

  // one comparator per breakpoint; breakpoints beyond the count never match
  generate
    for (genvar j = 1; j < 4; j++) begin : g_bp
      assign past_bp[j] = (2'(j) <= s.nbp) && (lim >= s.pt[j].inp);
    end
  endgenerate

  // piecewise-linear profile; divide is combinational, result registered
  always_comb begin
    if (past_bp[3]) begin
      seg = 2'h3;
    end else if (past_bp[2]) begin
      seg = 2'h2;
    end else if (past_bp[1]) begin
      seg = 2'h1;
    end else begin
      seg = 2'h0;
    end
    lo_p = s.pt[seg];
    hi_p = (seg == s.nbp) ? s.pt[4] : s.pt[3'(seg) + 3'h1];
    dx = 18'(lim) - 18'(lo_p.inp);
    dc = 18'(hi_p.cur) - 18'(lo_p.cur);
    den = 18'(hi_p.inp) - 18'(lo_p.inp);
    prod = 36'(dx) * 36'(dc);
    quo = (den > 18'sh0) ? prod / 36'(den) : 36'sh0;
    interp = 16'(18'(lo_p.cur) + 18'(quo));
    if (lim < s.smin || lim > s.smax) begin
      scaled = 16'h0000;
    end else if (lim <= s.pt[0].inp) begin
      scaled = s.pt[0].cur;
    end else if (lim >= s.pt[4].inp) begin
      scaled = s.pt[4].cur;
    end else begin
      scaled = interp;
    end
  end

  // byte lanes not strobed keep their old contents
  generate
    for (genvar b = 0; b < 4; b++) begin : g_strb
      assign m[8*b +: 8] = {8{pstrb[b]}};
    end
  endgenerate

  always_comb begin
    next_s = s;
    mapped = (paddr[1:0] == 2'h0) && (paddr <= A_SETP);
    pt_hit = (paddr >= A_PT0) && (paddr <= A_PT4);
    pt_idx = 3'((paddr - A_PT0) >> 2);
    case (paddr)
      A_CTRL: rd = 32'({s.b_en, s.nbp, s.bias, s.typ});
      A_ERR: rd = {s.emax, s.emin};
      A_IRAMP: rd = {s.rdn, s.rup};
      A_SIG: rd = {s.smax, s.smin};
      A_DIG0: rd = {s.dflt, s.dgnd};
      A_DIG1: rd = 32'(s.dbat);
      A_OFA: rd = 32'(s.oc[0].freq);
      A_ORA: rd = {s.oc[0].down, s.oc[0].up};
      A_OFB: rd = 32'(s.oc[1].freq);
      A_ORB: rd = {s.oc[1].down, s.oc[1].up};
      A_STAT: rd = {lim, 10'h000, s.hi, s.lo, 1'b0, s.flt, s.under, s.over};
      A_SETP: rd = {ramp[0], s.setpt};
      default: rd = (pt_hit && mapped) ? s.pt[pt_idx] : 32'h0000_0000;
    endcase
    w = (rd & ~m) | (pwdata & m);
    if (psel && !penable) begin
      next_s.rdata = rd;
    end
    if (psel && penable && pwrite && mapped) begin
      case (paddr)
        A_CTRL: begin
          next_s.typ = pvs_in_type_t'(w[2:0]);
          next_s.bias = pvs_bias_t'(w[4:3]);
          next_s.nbp = w[6:5];
          next_s.b_en = w[7];
        end
        A_ERR: begin
          next_s.emin = w[15:0];
          next_s.emax = w[31:16];
        end
        A_IRAMP: begin
          next_s.rup = w[15:0];
          next_s.rdn = w[31:16];
        end
        A_SIG: begin
          next_s.smin = w[15:0];
          next_s.smax = w[31:16];
        end
        A_DIG0: begin
          next_s.dgnd = w[15:0];
          next_s.dflt = w[31:16];
        end
        A_DIG1: next_s.dbat = w[15:0];
        A_OFA: next_s.oc[0].freq = clamp_f(w);
        A_ORA: begin
          next_s.oc[0].up = w[15:0];
          next_s.oc[0].down = w[31:16];
        end
        A_OFB: next_s.oc[1].freq = clamp_f(w);
        A_ORB: begin
          next_s.oc[1].up = w[15:0];
          next_s.oc[1].down = w[31:16];
        end
        default: begin
          if (pt_hit) begin
            next_s.pt[pt_idx] = w;
          end
        end
      endcase
    end

    // pin bias; weak pulls are analog, the block only enables them
    dig = (s.typ == IN_DIGITAL);
    next_s.pu = (s.bias == BIAS_UP) && (dig || s.typ == IN_PWM || s.typ == IN_FREQ);
    next_s.pd = (s.bias == BIAS_DOWN) && (dig || s.typ == IN_PWM || s.typ == IN_FREQ);
    next_s.pc = dig && (s.bias == BIAS_CENTER);

    // comparator pins: three flops, a change counts when the last two agree
    next_s.hi_s = {s.hi_s[1:0], in_above_hi};
    next_s.lo_s = {s.lo_s[1:0], in_below_lo};
    if (s.hi_s[1] == s.hi_s[2]) begin
      next_s.hi = s.hi_s[2];
    end
    if (s.lo_s[1] == s.lo_s[2]) begin
      next_s.lo = s.lo_s[2];
    end
    case (s.bias)
      BIAS_CENTER: begin
        if (s.hi) begin
          dsel = s.dbat;
        end else if (s.lo) begin
          dsel = s.dgnd;
        end else begin
          dsel = s.dflt;
        end
      end
      default: begin
        // two-state switch: the pull decides what an open contact reads
        dsel = s.hi ? s.dbat : s.dgnd;
      end
    endcase

    // digital switch has no meaningful range, so limits skip it
    // limits see the raw sample, so a slow input ramp cannot hide a fault
    if (!dig && s.emax != FULL_SCALE && in_sample > s.emax) begin
      next_s.over = 1'b1;
    end
    if (!dig && s.emin != ERR_MIN_OFF && in_sample < s.emin) begin
      next_s.under = 1'b1;
    end
    next_s.flt = s.over | s.under;
    if (s.flt) begin
      next_s.setpt = 16'h0000;
    end else if (dig) begin
      next_s.setpt = dsel;
    end else begin
      next_s.setpt = scaled;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
      s.emax <= ERR_MAX_RST;
      s.smax <= SIG_MAX_RST;
      s.oc[0].freq <= FREQ_RST;
      s.oc[1].freq <= FREQ_RST;
    end else begin
      s <= next_s;
    end
  end

  assign meas = {coil_ma_b, coil_ma_a};
  // output B idles unless enabled; a fault idles both
  assign en = {!s.flt && s.b_en, !s.flt};

  // output slew after scaling, then regulated PWM, one pair per channel
  generate
    for (genvar c = 0; c < 2; c++) begin : g_out
      pvs_ramp u_out_ramp (
        .pclk(pclk),
        .presetn(presetn),
        .target(s.setpt),
        .rate_up(s.oc[c].up),
        .rate_down(s.oc[c].down),
        .value(ramp[c])
      );
      pvs_coil_pwm u_pwm (
        .pclk(pclk),
        .presetn(presetn),
        .freq(s.oc[c].freq),
        .setpt(ramp[c]),
        .meas(meas[c]),
        .en(en[c]),
        .coil(pwm[c])
      );
    end
  endgenerate

  // zero wait states; read data is captured in the setup cycle
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata = s.rdata;
  assign pull_up_en = s.pu;
  assign pull_center_en = s.pc;
  assign pull_down_en = s.pd;
  assign coil_pwm_a = pwm[0];
  assign coil_pwm_b = pwm[1];
  assign fault = s.flt;
endmodule : pvs_scaler
`default_nettype wire

/* dv/pvs_properties.sv */
// Purpose: port checks of the valve input scaler
// Assumes: bound to every pvs_scaler instance
// Notes: one clock domain, so default clocking is used
`timescale 1ns/1ps
`default_nettype none
module pvs_properties
  import pvs_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic pull_up_en,
  input wire logic pull_center_en,
  input wire logic pull_down_en,
  input wire logic coil_pwm_a,
  input wire logic coil_pwm_b,
  input wire logic fault
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_rdy; pready; endproperty
  a_rdy: assert property (p_rdy) else $error("pready low");
  property p_acc; pslverr |-> psel && penable; endproperty
  a_acc: assert property (p_acc) else $error("error outside access");
  property p_unm; psel && penable && paddr > 8'h40 |-> pslverr; endproperty
  a_unm: assert property (p_unm) else $error("unmapped access accepted");
  property p_unal; psel && penable && paddr[1:0] != 2'h0 |-> pslverr; endproperty
  a_unal: assert property (p_unal) else $error("unaligned access accepted");
  property p_map; psel && penable && paddr <= 8'h40 && paddr[1:0] == 2'h0 |-> !pslverr;
  endproperty
  a_map: assert property (p_map) else $error("mapped access refused");
  // fault is only cleared by reset, so it must stand once raised
  property p_hold; fault |=> fault [*3]; endproperty
  a_hold: assert property (p_hold) else $error("fault dropped");
  property p_off; fault [*3] |-> !coil_pwm_a && !coil_pwm_b; endproperty
  a_off: assert property (p_off) else $error("coil driven in fault");
  property p_ctr; pull_center_en |-> !pull_up_en && !pull_down_en; endproperty
  a_ctr: assert property (p_ctr) else $error("centre bias mixed");
  property p_ud; !(pull_up_en && pull_down_en); endproperty
  a_ud: assert property (p_ud) else $error("up and down bias both on");
endmodule : pvs_properties
bind pvs_scaler pvs_properties chk (.pclk(pclk), .presetn(presetn), .paddr(paddr),
  .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
  .pull_up_en(pull_up_en), .pull_center_en(pull_center_en), .pull_down_en(pull_down_en),
  .coil_pwm_a(coil_pwm_a), .coil_pwm_b(coil_pwm_b), .fault(fault));
`default_nettype wire

/* dv/pvs_partner.sv */
// Purpose: switch pin and coil models on the far side
// Assumes: sw 0 ground, 1 float, 2 battery
// Notes: an unbiased floating pin toggles, so it never reads steady
`timescale 1ns/1ps
`default_nettype none
module pvs_partner
  import pvs_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [1:0] sw,
  input wire logic pull_up_en,
  input wire logic pull_center_en,
  input wire logic pull_down_en,
  input wire logic coil_pwm_a,
  input wire logic coil_pwm_b,
  output logic in_above_hi,
  output logic in_below_lo,
  output logic [15:0] coil_ma_a,
  output logic [15:0] coil_ma_b
);
  logic flip;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flip <= 1'b0;
      coil_ma_a <= 16'h0000;
      coil_ma_b <= 16'h0000;
    end else begin
      flip <= !flip;
      // crude coil lag: current creeps while the drive is on
      coil_ma_a <= coil_pwm_a ? coil_ma_a + 16'h0001
        : (coil_ma_a > 16'h0000 ? coil_ma_a - 16'h0001 : 16'h0000);
      coil_ma_b <= coil_pwm_b ? coil_ma_b + 16'h0001
        : (coil_ma_b > 16'h0000 ? coil_ma_b - 16'h0001 : 16'h0000);
    end
  end
  always_comb begin
    in_above_hi = (sw == 2'h2);
    in_below_lo = (sw == 2'h0);
    if (sw == 2'h1) begin
      // centre bias leaves both comparators off
      in_above_hi = pull_up_en || (!pull_down_en && !pull_center_en && flip);
      in_below_lo = pull_down_en || (!pull_up_en && !pull_center_en && !flip);
    end
  end
endmodule : pvs_partner
`default_nettype wire

/* dv/test_pvs_scaler.sv */
// Purpose: self-checking bench of the valve input scaler
// Assumes: slave may answer late, so every wait is bounded
// Notes: ramp checks allow two units of slack for read timing
`timescale 1ns/1ps
`default_nettype none
module test_pvs_scaler
  import pvs_pkg::*;
  ;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [15:0] in_sample = 16'h0;
  logic [1:0] sw = 2'h0;
  logic [31:0] prdata, q;
  logic [15:0] ma_a, ma_b;
  logic pready, pslverr, hi, lo, pu, pc, pd, pwa, pwb, fault, e;
  int err_total = 0;
  int comparisons = 0;
  int x, v;
  int fq[4] = '{39, 40, 400, 401};
  int sc[7] = '{40, 75, 100, 600, 1100, 1150, 1300};
  always #12.5 pclk = ~pclk;
  pvs_scaler dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .in_sample(in_sample), .in_above_hi(hi),
    .in_below_lo(lo), .coil_ma_a(ma_a), .coil_ma_b(ma_b), .pull_up_en(pu),
    .pull_center_en(pc), .pull_down_en(pd), .coil_pwm_a(pwa), .coil_pwm_b(pwb), .fault(fault));
  pvs_partner far (.pclk(pclk), .presetn(presetn), .sw(sw), .pull_up_en(pu),
    .pull_center_en(pc), .pull_down_en(pd), .coil_pwm_a(pwa), .coil_pwm_b(pwb),
    .in_above_hi(hi), .in_below_lo(lo), .coil_ma_a(ma_a), .coil_ma_b(ma_b));
  function automatic int clampf(int f);
    return f < 40 ? 40 : (f > 400 ? 400 : f);
  endfunction : clampf
  function automatic int scale(int s, int nb);
    if (s < 50 || s > 1200) return 0;
    if (s <= 100) return 200;
    if (s >= 1100) return 1200;
    if (nb == 1) return s <= 600 ? 200 + 2 * (s - 100) : 1200;
    return s + 100;
  endfunction : scale
  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict
  task automatic flag(bit bad, string m);
    comparisons++;
    if (bad) begin
      err_total++;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask : flag
  task automatic cyc(int n);
    repeat (n) @(posedge pclk);
  endtask : cyc
  task automatic rst();
    presetn <= 1'b0;
    cyc(2);
    presetn <= 1'b1;
    cyc(1);
  endtask : rst
  task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      flag(1'b1, "bus hang");
      give_verdict();
    end
    @(posedge pclk);
  endtask : apb
  task automatic rc(logic [7:0] a, logic [31:0] x0, logic e0);
    apb(1'b0, a, 32'h0);
    flag(q !== x0 || e !== e0, "register read");
  endtask : rc
  task automatic rn(logic [7:0] a, bit up, int c);
    logic [15:0] g;
    apb(1'b0, a, 32'h0);
    g = up ? q[31:16] : q[15:0];
    flag($isunknown(g) || g < c - 2 || g > c + 2, "ramped value");
  endtask : rn
  initial begin
    void'($urandom(76));
    rst();
    rc(A_CTRL, 32'h0, 1'b0);
    rc(A_ERR, 32'hFFFF0000, 1'b0);
    rc(A_SIG, 32'hFFFF0000, 1'b0);
    rc(A_OFB, 32'h000000C8, 1'b0);
    rc(8'h44, 32'h0, 1'b1);
    rc(8'h06, 32'h0, 1'b1);
    $display("done: registers");
    for (int i = 0; i < 8; i++) begin
      v = i < 4 ? fq[i] : $urandom_range(0, 600);
      apb(1'b1, A_OFA, 32'(v));
      apb(1'b1, A_OFB, 32'(600 - v));
      rc(A_OFA, 32'(clampf(v)), 1'b0);
      rc(A_OFB, 32'(clampf(600 - v)), 1'b0);
    end
    $display("done: frequency");
    apb(1'b1, A_DIG0, 32'h01F4012C);
    apb(1'b1, A_DIG1, 32'h000002BC);
    for (int b = 0; b < 3; b++) begin
      apb(1'b1, A_CTRL, 32'(5 + 8 * b));
      for (int s = 0; s < 3; s++) begin
        sw <= 2'(s);
        cyc(12);
        x = s == 2 ? 700 : (s == 0 ? 300 : (b == 1 ? 500 : (b == 0 ? 700 : 300)));
        rc(A_SETP, {16'(x), 16'(x)}, 1'b0);
        flag({pu, pc, pd} !== 3'(4 >> b), "bias enables");
      end
    end
    apb(1'b1, A_CTRL, 32'h8);
    cyc(2);
    flag({pu, pc, pd} !== 3'b000, "bias on analog input");
    for (int t = 3; t < 8; t++) begin
      apb(1'b1, A_CTRL, 32'(t + 16));
      cyc(2);
      flag({pu, pc, pd} !== (t > 4 ? 3'b001 : 3'b000), "bias by input type");
    end
    $display("done: digital input");
    apb(1'b1, A_SIG, 32'h04B00032);
    apb(1'b1, A_PT0, 32'h00C80064);
    apb(1'b1, A_PT0 + 8'h04, 32'h04B00258);
    apb(1'b1, A_PT4, 32'h04B0044C);
    for (int nb = 0; nb < 2; nb++) begin
      apb(1'b1, A_CTRL, 32'(nb * 32));
      for (int i = 0; i < 15; i++) begin
        x = i < 7 ? sc[i] : $urandom_range(100, 1100);
        in_sample <= 16'(x);
        cyc(6);
        apb(1'b0, A_SETP, 32'h0);
        flag(q[15:0] !== 16'(scale(x, nb)), "scaled set point");
      end
    end
    $display("done: scaling");
    apb(1'b1, A_CTRL, 32'h0);
    in_sample <= 16'd100;
    cyc(6);
    apb(1'b1, A_IRAMP, 32'h9C409C40);
    in_sample <= 16'd110;
    cyc(5000);
    rn(A_STAT, 1'b1, 105);
    rn(A_SETP, 1'b0, 205);
    in_sample <= 16'd90;
    cyc(5000);
    rn(A_STAT, 1'b1, 100);
    apb(1'b1, A_IRAMP, 32'h0);
    in_sample <= 16'd500;
    cyc(6);
    apb(1'b1, A_ORA, 32'h9C409C40);
    in_sample <= 16'd520;
    cyc(10000);
    rn(A_SETP, 1'b1, 610);
    in_sample <= 16'd480;
    cyc(10000);
    rn(A_SETP, 1'b1, 600);
    $display("done: ramps");
    rst();
    in_sample <= 16'hFFFF;
    cyc(8);
    flag(fault !== 1'b0, "over check active");
    in_sample <= 16'h0;
    cyc(8);
    flag(fault !== 1'b0, "under check active");
    for (int k = 0; k < 2; k++) begin
      in_sample <= 16'd500;
      apb(1'b1, A_ERR, 32'h03E80032);
      in_sample <= k ? 16'd50 : 16'd1000;
      cyc(8);
      flag(fault !== 1'b0, "fault at limit");
      in_sample <= k ? 16'd49 : 16'd1001;
      cyc(8);
      apb(1'b0, A_STAT, 32'h0);
      flag(q[2:0] !== (k ? 3'b110 : 3'b101) || fault !== 1'b1, "fault latch");
      flag(pwa !== 1'b0 || pwb !== 1'b0, "coil driven in fault");
      rst();
    end
    $display("done: faults");
    give_verdict();
  end
endmodule : test_pvs_scaler
`default_nettype wire
